// ### src/slrx_pkg.sv
package slrx_pkg;
   localparam int          ADDR_W                = 10;
   localparam logic [9:0]  OFF_TERM2_CTRL        = 10'h2AE;
   localparam logic [9:0]  OFF_GENERAL_CTRL      = 10'h300;
   localparam logic [9:0]  OFF_SUBCLASS_CTRL     = 10'h301;
   localparam logic [9:0]  OFF_LINK0_LATENCY     = 10'h302;
   localparam logic [9:0]  OFF_LINK1_LATENCY     = 10'h303;
   localparam logic [9:0]  OFF_LINK0_MF_DELAY    = 10'h304;
   localparam logic [9:0]  OFF_LINK1_MF_DELAY    = 10'h305;
   localparam logic [9:0]  OFF_LINK0_READOUT     = 10'h306;
   localparam logic [9:0]  OFF_LINK1_READOUT     = 10'h307;
   localparam int          BIT_CHECKSUM_METHOD   = 6;
   localparam int          BIT_TWO_LINK_SELECT   = 3;
   localparam int          BIT_PAGE_SELECT       = 2;
   localparam int          BIT_TERM2_CAL         = 0;
   localparam logic [1:0]  RST_ENABLES           = 2'h0;
   localparam logic [5:0]  RST_GENERAL_RW        = 6'h00;
   localparam logic [2:0]  RST_LOCAL_SUBCLASS    = 3'h1;
   localparam logic [4:0]  RST_MF_DELAY          = 5'h00;
   localparam logic [4:0]  RST_READOUT_POINT     = 5'h06;
   localparam logic [4:0]  READOUT_MAX_ADVISED   = 5'h0A;
   localparam logic [7:0]  UNMAPPED_READ         = 8'h00;
endpackage

// ### src/slrx_edge_pulse.sv
`timescale 1ns/1ps
// one-cycle pulse on a 0-to-1 transition of a level written by software
module slrx_edge_pulse (
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   input  wire logic level_i,
   output logic      pulse_o
);
   logic last;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last <= 1'b0;
      end else begin
         last <= level_i;
      end
   end

   // a level held high never retriggers
   assign pulse_o = level_i & ~last;
endmodule // slrx_edge_pulse

// ### src/slrx_regs.sv
`timescale 1ns/1ps
module slrx_regs (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   // register port from the serial programming logic, same clock
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [9:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic [7:0]      reg_rdata_o,
   // measured latencies from the deframers, same clock
   input  wire logic [4:0] link0_measured_latency_i,
   input  wire logic [4:0] link1_measured_latency_i,
   // controls to the receive digital
   output logic            term2_cal_start_o,
   output logic            checksum_method_o,
   output logic            two_link_select_o,
   output logic            page_select_o,
   output logic            link_page_zero_o,
   output logic            link_page_one_o,
   output logic [1:0]      link_bringup_enables_o,
   output logic            link0_run_o,
   output logic            link1_run_o,
   output logic [2:0]      local_subclass_o,
   output logic            subclass1_mode_o,
   output logic [4:0]      link0_global_mf_delay_o,
   output logic [4:0]      link1_global_mf_delay_o,
   output logic [4:0]      link0_readout_point_o,
   output logic [4:0]      link1_readout_point_o,
   output logic            readout_point_advisory_o
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic       term2_cal_trigger;
   logic       checksum_method;
   logic [1:0] general_spare;
   logic       two_link_select;
   logic       page_select;
   logic [1:0] link_bringup_enables;
   logic [2:0] local_subclass;
   logic [4:0] link0_global_mf_delay;
   logic [4:0] link1_global_mf_delay;
   logic [4:0] link0_readout_point;
   logic [4:0] link1_readout_point;
   logic [7:0] rdata;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire sel_term2    = reg_addr_i == slrx_pkg::OFF_TERM2_CTRL;
   wire sel_general  = reg_addr_i == slrx_pkg::OFF_GENERAL_CTRL;
   wire sel_subclass = reg_addr_i == slrx_pkg::OFF_SUBCLASS_CTRL;
   wire sel_lat0     = reg_addr_i == slrx_pkg::OFF_LINK0_LATENCY;
   wire sel_lat1     = reg_addr_i == slrx_pkg::OFF_LINK1_LATENCY;
   wire sel_del0     = reg_addr_i == slrx_pkg::OFF_LINK0_MF_DELAY;
   wire sel_del1     = reg_addr_i == slrx_pkg::OFF_LINK1_MF_DELAY;
   wire sel_var0     = reg_addr_i == slrx_pkg::OFF_LINK0_READOUT;
   wire sel_var1     = reg_addr_i == slrx_pkg::OFF_LINK1_READOUT;

   wire wr_term2    = reg_wr_i & sel_term2;
   wire wr_general  = reg_wr_i & sel_general;
   wire wr_subclass = reg_wr_i & sel_subclass;
   wire wr_del0     = reg_wr_i & sel_del0;
   wire wr_del1     = reg_wr_i & sel_del1;
   wire wr_var0     = reg_wr_i & sel_var0;
   wire wr_var1     = reg_wr_i & sel_var1;

   // ------------------------------------------------------------
   // writable fields
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         term2_cal_trigger    <= 1'b0;
         checksum_method      <= slrx_pkg::RST_GENERAL_RW[5];
         general_spare        <= slrx_pkg::RST_GENERAL_RW[4:3];
         two_link_select      <= slrx_pkg::RST_GENERAL_RW[2];
         page_select          <= slrx_pkg::RST_GENERAL_RW[1];
         link_bringup_enables <= slrx_pkg::RST_ENABLES;
      end else begin
         if (wr_term2) begin
            term2_cal_trigger <= reg_wdata_i[slrx_pkg::BIT_TERM2_CAL];
         end
         if (wr_general) begin
            checksum_method      <= reg_wdata_i[slrx_pkg::BIT_CHECKSUM_METHOD];
            general_spare        <= reg_wdata_i[5:4];
            two_link_select      <= reg_wdata_i[slrx_pkg::BIT_TWO_LINK_SELECT];
            page_select          <= reg_wdata_i[slrx_pkg::BIT_PAGE_SELECT];
            link_bringup_enables <= reg_wdata_i[1:0];  // both bits land in one write
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         local_subclass        <= slrx_pkg::RST_LOCAL_SUBCLASS;
         link0_global_mf_delay <= slrx_pkg::RST_MF_DELAY;
         link1_global_mf_delay <= slrx_pkg::RST_MF_DELAY;
         link0_readout_point   <= slrx_pkg::RST_READOUT_POINT;
         link1_readout_point   <= slrx_pkg::RST_READOUT_POINT;
      end else begin
         if (wr_subclass) begin
            local_subclass <= reg_wdata_i[2:0];
         end
         if (wr_del0) begin
            link0_global_mf_delay <= reg_wdata_i[4:0];
         end
         if (wr_del1) begin
            link1_global_mf_delay <= reg_wdata_i[4:0];
         end
         if (wr_var0) begin
            link0_readout_point <= reg_wdata_i[4:0];
         end
         if (wr_var1) begin
            link1_readout_point <= reg_wdata_i[4:0];
         end
      end
   end

   // ------------------------------------------------------------
   // calibration start
   // ------------------------------------------------------------
   slrx_edge_pulse u_term2_edge (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .level_i   (term2_cal_trigger),
      .pulse_o   (term2_cal_start_o)
   );

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // latency registers have no write path, so writes to them are dropped
   wire [7:0] rd_term2    = {7'h00, term2_cal_trigger};
   wire [7:0] rd_general  = {1'b0, checksum_method, general_spare, two_link_select,
                             page_select, link_bringup_enables};
   wire [7:0] rd_subclass = {5'h00, local_subclass};
   wire [7:0] rd_lat0     = {3'h0, link0_measured_latency_i};
   wire [7:0] rd_lat1     = {3'h0, link1_measured_latency_i};
   wire [7:0] rd_del0     = {3'h0, link0_global_mf_delay};
   wire [7:0] rd_del1     = {3'h0, link1_global_mf_delay};
   wire [7:0] rd_var0     = {3'h0, link0_readout_point};
   wire [7:0] rd_var1     = {3'h0, link1_readout_point};

   wire [7:0] next_rdata = sel_term2    ? rd_term2    :
                           sel_general  ? rd_general  :
                           sel_subclass ? rd_subclass :
                           sel_lat0     ? rd_lat0     :
                           sel_lat1     ? rd_lat1     :
                           sel_del0     ? rd_del0     :
                           sel_del1     ? rd_del1     :
                           sel_var0     ? rd_var0     :
                           sel_var1     ? rd_var1     : slrx_pkg::UNMAPPED_READ;

   // read data is held until the next read
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata <= slrx_pkg::UNMAPPED_READ;
      end else if (reg_rd_i) begin
         rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // controls
   // ------------------------------------------------------------
   assign reg_rdata_o             = rdata;
   assign checksum_method_o       = checksum_method;
   assign two_link_select_o       = two_link_select;
   assign page_select_o           = page_select;
   assign link_page_zero_o        = ~page_select;
   assign link_page_one_o         = page_select;
   assign link_bringup_enables_o  = link_bringup_enables;
   assign link0_run_o             = link_bringup_enables[0];
   // link 1 run is gated by the mode, so a stray enable in single mode stays off link1_run_o but still shows on link_bringup_enables_o
   assign link1_run_o             = link_bringup_enables[1] & two_link_select;
   assign local_subclass_o        = local_subclass;
   assign subclass1_mode_o        = local_subclass == 3'h1;
   assign link0_global_mf_delay_o = link0_global_mf_delay;
   assign link1_global_mf_delay_o = link1_global_mf_delay;
   assign link0_readout_point_o   = link0_readout_point;
   assign link1_readout_point_o   = link1_readout_point;
   // flags values above the advised limit; software is expected to avoid them
   assign readout_point_advisory_o = (link0_readout_point > slrx_pkg::READOUT_MAX_ADVISED) |
                                     (link1_readout_point > slrx_pkg::READOUT_MAX_ADVISED);
endmodule // slrx_regs

// ### tb/slrx_regs_sva.sv
`timescale 1ns/1ps
module slrx_regs_sva (
   input wire logic       ref_clk_i,
   input wire logic       rst_n_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [9:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [4:0] link0_measured_latency_i,
   input wire logic       term2_cal_start_o,
   input wire logic       checksum_method_o,
   input wire logic       two_link_select_o,
   input wire logic       page_select_o,
   input wire logic       link_page_zero_o,
   input wire logic       link_page_one_o,
   input wire logic [1:0] link_bringup_enables_o,
   input wire logic       link0_run_o,
   input wire logic       link1_run_o,
   input wire logic [2:0] local_subclass_o,
   input wire logic       subclass1_mode_o,
   input wire logic [4:0] link0_global_mf_delay_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // level last written to the calibration bit, so a rewrite of 1 is told apart from a 0-to-1 edge
   logic cal_level;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cal_level <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == slrx_pkg::OFF_TERM2_CTRL) begin
         cal_level <= reg_wdata_i[slrx_pkg::BIT_TERM2_CAL];
      end
   end
   sequence s_cal_cause;
      $past(reg_wr_i && reg_addr_i == slrx_pkg::OFF_TERM2_CTRL && reg_wdata_i[0] && !cal_level);
   endsequence
   chk_cal_pulse: assert property (term2_cal_start_o |-> s_cal_cause ##1 !term2_cal_start_o)
      else $error("calibration start not a single pulse after a rising write");
   chk_cal_start: assert property (reg_wr_i && reg_addr_i == slrx_pkg::OFF_TERM2_CTRL && reg_wdata_i[0]
      && !cal_level |=> term2_cal_start_o)
      else $error("calibration start missing after a rising write");
   chk_general_write: assert property (reg_wr_i && reg_addr_i == 10'h300 |=>
      checksum_method_o == $past(reg_wdata_i[6]) && two_link_select_o == $past(reg_wdata_i[3]))
      else $error("mode bits do not follow the write");
   chk_page_route: assert property (reg_wr_i && reg_addr_i == slrx_pkg::OFF_GENERAL_CTRL |=>
      page_select_o == $past(reg_wdata_i[2]) && link_page_one_o == $past(reg_wdata_i[2])
      && link_page_zero_o == !$past(reg_wdata_i[2]))
      else $error("page routing does not follow the write");
   chk_link0_run: assert property (reg_wr_i && reg_addr_i == slrx_pkg::OFF_GENERAL_CTRL |=>
      link_bringup_enables_o == $past(reg_wdata_i[1:0]) && link0_run_o == $past(reg_wdata_i[0]))
      else $error("link enables do not follow the write");
   chk_link1_gate: assert property (link1_run_o == (link_bringup_enables_o[1] && two_link_select_o))
      else $error("link 1 run not gated by two-link mode");
   chk_latency_read: assert property (reg_rd_i && reg_addr_i == 10'h302 |=>
      reg_rdata_o == {3'h0, $past(link0_measured_latency_i)})
      else $error("latency read value wrong");
   chk_delay_write: assert property (reg_wr_i && reg_addr_i == 10'h304 |=>
      link0_global_mf_delay_o == $past(reg_wdata_i[4:0]))
      else $error("delay does not follow the write");
   chk_subclass_mode: assert property (reg_wr_i && reg_addr_i == slrx_pkg::OFF_SUBCLASS_CTRL |=>
      local_subclass_o == $past(reg_wdata_i[2:0]) && subclass1_mode_o == ($past(reg_wdata_i[2:0]) == 3'h1))
      else $error("subclass field or mode flag does not follow the write");
endmodule // slrx_regs_sva
bind slrx_regs slrx_regs_sva u_slrx_regs_sva (.*);

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic       ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, term2_cal_start_o, checksum_method_o;
   logic       two_link_select_o, page_select_o, link_page_zero_o, link_page_one_o;
   logic       link0_run_o, link1_run_o, subclass1_mode_o, readout_point_advisory_o;
   logic [1:0] link_bringup_enables_o;
   logic [2:0] local_subclass_o;
   logic [4:0] link0_measured_latency_i, link1_measured_latency_i, link0_global_mf_delay_o;
   logic [4:0] link1_global_mf_delay_o, link0_readout_point_o, link1_readout_point_o;
   logic [7:0] reg_wdata_i, reg_rdata_o;
   logic [9:0] reg_addr_i;
   logic [7:0] mode_w [6] = '{8'h40, 8'h0B, 8'h02, 8'h07, 8'h09, 8'h0A};
   logic [4:0] mode_e [6] = '{5'h10, 5'h0B, 5'h00, 5'h05, 5'h09, 5'h0A};
   int         num_errors = 0, num_checks = 0, cycles = 0;
   slrx_regs u_slrx_regs (.*);
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // strobes rise after one edge and drop at the taking edge
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      check(reg_rdata_o, exp);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
      link0_measured_latency_i = 5'h15;
      link1_measured_latency_i = 5'h0A;
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd(10'h2AE, 8'h00);
      rd(10'h300, 8'h00);
      rd(10'h301, 8'h01);
      rd(10'h302, 8'h15);
      rd(10'h303, 8'h0A);
      rd(10'h304, 8'h00);
      rd(10'h305, 8'h00);
      rd(10'h306, 8'h06);
      rd(10'h307, 8'h06);
      rd(10'h3FF, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(10'h300, mode_w[i]);
         check({3'h0, checksum_method_o, two_link_select_o, page_select_o, link1_run_o, link0_run_o},
               {3'h0, mode_e[i]});
         check({6'h0, link_bringup_enables_o}, {6'h0, mode_w[i][1:0]});
         check({6'h0, link_page_one_o, link_page_zero_o}, {6'h0, mode_w[i][2], ~mode_w[i][2]});
      end
      wr(10'h300, 8'hFF);
      rd(10'h300, 8'h7F);
      wr(10'h302, 8'hFF);
      rd(10'h302, 8'h15);
      wr(10'h303, 8'hFF);
      rd(10'h303, 8'h0A);
      @(posedge ref_clk_i);
      link0_measured_latency_i <= 5'h03;
      rd(10'h302, 8'h03);
      wr(10'h304, 8'hFF);
      check({3'h0, link0_global_mf_delay_o}, 8'h1F);
      rd(10'h304, 8'h1F);
      wr(10'h305, 8'h13);
      check({3'h0, link1_global_mf_delay_o}, 8'h13);
      wr(10'h306, 8'h0A);
      check({3'h0, link0_readout_point_o}, 8'h0A);
      check({7'h0, readout_point_advisory_o}, 8'h00);
      wr(10'h307, 8'h03);
      check({3'h0, link1_readout_point_o}, 8'h03);
      // one value past the advice on purpose, so the advisory flag is seen to rise
      wr(10'h307, 8'h0B);
      check({7'h0, readout_point_advisory_o}, 8'h01);
      wr(10'h301, 8'h00);
      check({7'h0, subclass1_mode_o}, 8'h00);
      check({5'h0, local_subclass_o}, 8'h00);
      wr(10'h301, 8'hF9);
      check({4'h0, subclass1_mode_o, local_subclass_o}, 8'h09);
      rd(10'h301, 8'h01);
      wr(10'h2AE, 8'h01);
      check({7'h0, term2_cal_start_o}, 8'h01);
      @(posedge ref_clk_i);
      #1;
      check({7'h0, term2_cal_start_o}, 8'h00);
      wr(10'h2AE, 8'h01);
      check({7'h0, term2_cal_start_o}, 8'h00);
      wr(10'h2AE, 8'h00);
      wr(10'h2AE, 8'h01);
      check({7'h0, term2_cal_start_o}, 8'h01);
      // mid-run reset: the cal pulse, the advisory flag and the fields at 0x307, 0x301, 0x300 and 0x2AE must fall back to their reset values
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      #1;
      check({7'h0, term2_cal_start_o}, 8'h00);
      check({7'h0, readout_point_advisory_o}, 8'h00);
      rd(10'h307, 8'h06);
      rd(10'h301, 8'h01);
      rd(10'h300, 8'h00);
      rd(10'h2AE, 8'h00);
      close_out();
   end
endmodule // testbench
